// [verilog/pmt_pkg.sv]
// ----------------------------------------------------------------
// period match timer constants
// ----------------------------------------------------------------
`default_nettype none
package pmt_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the apb port
  // ----------------------------------------------------------------
  localparam int unsigned PMT_ADDR_W = 12;
  localparam logic [11:0] PMT_OFF_CONTROL = 12'h000;
  localparam logic [11:0] PMT_OFF_COUNT = 12'h004;
  localparam logic [11:0] PMT_OFF_LIMIT = 12'h008;
  localparam logic [11:0] PMT_OFF_IRQ_STATUS = 12'h00C;
  localparam logic [11:0] PMT_OFF_IRQ_CLEAR = 12'h010;
  localparam logic [11:0] PMT_OFF_IRQ_ENABLE = 12'h014;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned PMT_CTRL_W = 7;
  localparam int unsigned PMT_CTRL_PRESCALE_LSB = 0;
  localparam int unsigned PMT_CTRL_PRESCALE_MSB = 1;
  localparam int unsigned PMT_CTRL_RUN_BIT = 2;
  localparam int unsigned PMT_CTRL_POSTSCALE_LSB = 3;
  localparam int unsigned PMT_CTRL_POSTSCALE_MSB = 6;

  // ----------------------------------------------------------------
  // interrupt register fields
  // ----------------------------------------------------------------
  localparam int unsigned PMT_IRQ_MATCH_BIT = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_LIMIT_RST = 8'hFF;
  localparam logic PMT_FLAG_RST = 1'b0;
  localparam logic PMT_IRQ_EN_RST = 1'b0;

  // ----------------------------------------------------------------
  // prescale codes and their ratios minus one
  // ----------------------------------------------------------------
  localparam logic [1:0] PMT_PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PMT_PRESCALE_DIV4 = 2'h1;
  localparam logic [3:0] PMT_PRESC_M1_DIV1 = 4'h0;
  localparam logic [3:0] PMT_PRESC_M1_DIV4 = 4'h3;
  localparam logic [3:0] PMT_PRESC_M1_DIV16 = 4'hF;

  // ----------------------------------------------------------------
  // timing: pclk cycles per instruction cycle
  // ----------------------------------------------------------------
  localparam int unsigned PMT_FOSC_PER_INSTR = 4;

endpackage
`default_nettype wire

// [verilog/pmt_scaler.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// modulo event scaler, ratio is ratio_m1 plus one
// ----------------------------------------------------------------
module pmt_scaler #(
  parameter int unsigned W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic tick_in,
  input wire logic [W-1:0] ratio_m1,
  output logic tick_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } pmt_scaler_state_t;

  pmt_scaler_state_t state_reg;
  pmt_scaler_state_t state_next;
  logic at_end;

  // a ratio lowered below the running count ends the cycle at once
  assign at_end = (state_reg.cnt >= ratio_m1);

  always_comb begin
    state_next = state_reg;
    tick_out = 1'b0;
    if (clr) begin
      state_next.cnt = '0;
    end else if (tick_in) begin
      if (at_end) begin
        state_next.cnt = '0;
        tick_out = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

// [verilog/pmt_timer.sv]
// Contract
// - count steps once per prescaled tick, wraps to zero after matching the limit
// - limit register is read/write and resets to all ones
// - prescale code 00 divides by 1, 01 by 4, 1x by 16
// - postscaler ratio is the four-bit select value plus one
// - match flag is set each time the postscaler completes its ratio
// - writes to count or control and reset clear both scalers
// - a control write leaves the count value untouched
// - count register is read/write and resets to zero
// - counter runs only while control bit 2 is one, zero at reset
// - match pulse is exported as the pwm time base
// - match pulse before the postscaler feeds the serial port shift clock
`timescale 1ns/1ns
`default_nettype none

module pmt_timer import pmt_pkg::*; #(
  parameter int unsigned FOSC_PER_INSTR = PMT_FOSC_PER_INSTR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic pwm_time_base,
  output logic serial_shift_tick
);

  // ----------------------------------------------------------------
  // local widths
  // ----------------------------------------------------------------
  localparam int unsigned PH_W = (FOSC_PER_INSTR > 1) ? $clog2(FOSC_PER_INSTR) : 1;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(FOSC_PER_INSTR - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PH_W-1:0] phase;
    logic [PMT_CTRL_W-1:0] control;
    logic [7:0] count;
    logic [7:0] limit;
    logic match_flag;
    logic match_irq_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic pwm_time_base;
    logic serial_shift_tick;
  } pmt_state_t;

  pmt_state_t state_reg;
  pmt_state_t state_next;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic apb_setup;
  logic apb_commit;
  logic wr_control;
  logic wr_count;
  logic wr_limit;
  logic wr_irq_clear;
  logic wr_irq_enable;
  logic addr_mapped;
  logic [31:0] rdata;

  // one wait state: pready is registered, the write lands at the pready edge
  assign apb_setup = psel && penable && !state_reg.pready;
  assign apb_commit = psel && penable && state_reg.pready;

  always_comb begin
    wr_control = 1'b0;
    wr_count = 1'b0;
    wr_limit = 1'b0;
    wr_irq_clear = 1'b0;
    wr_irq_enable = 1'b0;
    addr_mapped = 1'b1;
    rdata = 32'h0000_0000;
    if (paddr == PMT_OFF_CONTROL) begin
      wr_control = apb_commit && pwrite;
      rdata = {25'h000_0000, state_reg.control};
    end else if (paddr == PMT_OFF_COUNT) begin
      wr_count = apb_commit && pwrite;
      rdata = {24'h00_0000, state_reg.count};
    end else if (paddr == PMT_OFF_LIMIT) begin
      wr_limit = apb_commit && pwrite;
      rdata = {24'h00_0000, state_reg.limit};
    end else if (paddr == PMT_OFF_IRQ_STATUS) begin
      rdata = {31'h0000_0000, state_reg.match_flag};
    end else if (paddr == PMT_OFF_IRQ_CLEAR) begin
      wr_irq_clear = apb_commit && pwrite;
    end else if (paddr == PMT_OFF_IRQ_ENABLE) begin
      wr_irq_enable = apb_commit && pwrite;
      rdata = {31'h0000_0000, state_reg.match_irq_en};
    end else begin
      addr_mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock chain
  // ----------------------------------------------------------------
  logic instr_tick;
  logic run;
  logic scaler_clr;
  logic [3:0] presc_m1;
  logic [3:0] post_m1;
  logic presc_tick;
  logic post_tick;
  logic match_event;

  assign instr_tick = (state_reg.phase == PH_LAST);
  assign run = state_reg.control[PMT_CTRL_RUN_BIT];
  assign scaler_clr = wr_control || wr_count;
  assign post_m1 = state_reg.control[PMT_CTRL_POSTSCALE_MSB:PMT_CTRL_POSTSCALE_LSB];

  always_comb begin
    if (state_reg.control[PMT_CTRL_PRESCALE_MSB:PMT_CTRL_PRESCALE_LSB] == PMT_PRESCALE_DIV1) begin
      presc_m1 = PMT_PRESC_M1_DIV1;
    end else if (state_reg.control[PMT_CTRL_PRESCALE_MSB:PMT_CTRL_PRESCALE_LSB]
                 == PMT_PRESCALE_DIV4) begin
      presc_m1 = PMT_PRESC_M1_DIV4;
    end else begin
      presc_m1 = PMT_PRESC_M1_DIV16;
    end
  end

  pmt_scaler #(
    .W(4)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clr(scaler_clr),
    .tick_in(instr_tick && run),
    .ratio_m1(presc_m1),
    .tick_out(presc_tick)
  );

  // a count write in the same cycle clears the prescaler, so no tick slips past it
  assign match_event = presc_tick && (state_reg.count == state_reg.limit);

  pmt_scaler #(
    .W(4)
  ) u_postscaler (
    .pclk(pclk),
    .presetn(presetn),
    .clr(scaler_clr),
    .tick_in(match_event),
    .ratio_m1(post_m1),
    .tick_out(post_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // instruction phase divider runs free, independent of the run bit
    if (instr_tick) begin
      state_next.phase = '0;
    end else begin
      state_next.phase = state_reg.phase + 1'b1;
    end

    if (presc_tick) begin
      if (state_reg.count == state_reg.limit) begin
        state_next.count = 8'h00;
      end else begin
        state_next.count = state_reg.count + 8'h01;
      end
    end

    if (wr_count) begin
      state_next.count = pwdata[7:0];
    end

    if (wr_control) begin
      state_next.control = pwdata[PMT_CTRL_W-1:0];
    end

    if (wr_limit) begin
      state_next.limit = pwdata[7:0];
    end

    if (wr_irq_enable) begin
      state_next.match_irq_en = pwdata[PMT_IRQ_MATCH_BIT];
    end

    if (wr_irq_clear && pwdata[PMT_IRQ_MATCH_BIT]) begin
      state_next.match_flag = 1'b0;
    end
    if (post_tick) begin
      state_next.match_flag = 1'b1;
    end

    state_next.irq = state_next.match_flag && state_next.match_irq_en;

    state_next.pwm_time_base = match_event;
    state_next.serial_shift_tick = match_event;

    // bus answer, one cycle of pready per access
    state_next.pready = apb_setup;
    state_next.pslverr = apb_setup && !addr_mapped;
    if (apb_setup && !pwrite) begin
      state_next.prdata = rdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.phase <= '0;
      state_reg.control <= PMT_CONTROL_RST;
      state_reg.count <= PMT_COUNT_RST;
      state_reg.limit <= PMT_LIMIT_RST;
      state_reg.match_flag <= PMT_FLAG_RST;
      state_reg.match_irq_en <= PMT_IRQ_EN_RST;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.irq <= 1'b0;
      state_reg.pwm_time_base <= 1'b0;
      state_reg.serial_shift_tick <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq = state_reg.irq;
  assign pwm_time_base = state_reg.pwm_time_base;
  assign serial_shift_tick = state_reg.serial_shift_tick;

endmodule

`default_nettype wire

// [dv/pmt_timer_sva.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module pmt_timer_sva import pmt_pkg::*; #(
  parameter int unsigned FOSC_PER_INSTR = PMT_FOSC_PER_INSTR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic pwm_time_base,
  input wire logic serial_shift_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since last match pulse; saturates so reset needs no special case
  logic [15:0] gap_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_reg <= 16'hFFFF;
    else if (pwm_time_base) gap_reg <= 16'h0001;
    else if (gap_reg != 16'hFFFF) gap_reg <= gap_reg + 16'h0001;
  end
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside an answer");
  a_read_upper_zero: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_ctrl_top_zero: assert property (
    pready && !pwrite && paddr == PMT_OFF_CONTROL |-> !prdata[7])
    else $error("control bit 7 not zero");
  a_shift_same_pwm: assert property (serial_shift_tick == pwm_time_base)
    else $error("shift tick differs from match pulse");
  a_pulse_spacing: assert property (pwm_time_base |-> gap_reg >= 16'(FOSC_PER_INSTR))
    else $error("match pulses too close");
  a_stop_no_pulse: assert property (
    pready && pwrite && paddr == PMT_OFF_CONTROL && !pwdata[2] |=> !pwm_time_base [*3])
    else $error("match pulse while stopped");
  a_irq_mask_off: assert property (
    pready && pwrite && paddr == PMT_OFF_IRQ_ENABLE && !pwdata[0] |-> ##[1:2] !irq)
    else $error("irq stays high when disabled");
  a_irq_rise_cause: assert property ($rose(irq) |-> pwm_time_base ||
    ($past(pready) && $past(pwrite)) || ($past(pready, 2) && $past(pwrite, 2)))
    else $error("irq rose without a cause");
endmodule
bind pmt_timer pmt_timer_sva #(.FOSC_PER_INSTR(FOSC_PER_INSTR)) i_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .pwm_time_base(pwm_time_base), .serial_shift_tick(serial_shift_tick));
`default_nettype wire

// [dv/period_match_timer8_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module period_match_timer8_tb_top import pmt_pkg::*;;
  localparam int unsigned FOSC = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pwm, shift, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  int err_total, compares, cyc;
  pmt_timer #(.FOSC_PER_INSTR(FOSC)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .pwm_time_base(pwm),
    .serial_shift_tick(shift));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard, well above the roughly two thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // read right at the edge: these are the values that edge samples
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rdv, e, "read data");
  endtask
  task wait_pulse(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pwm !== 1'b1);
  endtask
  task t_regs;
    rd(PMT_OFF_CONTROL, 32'h00000000);
    rd(PMT_OFF_COUNT, 32'h00000000);
    rd(PMT_OFF_LIMIT, 32'h000000FF);
    apb(1'b1, PMT_OFF_LIMIT, 32'h0000005A);
    rd(PMT_OFF_LIMIT, 32'h0000005A);
    apb(1'b1, PMT_OFF_COUNT, 32'h00000033);
    rd(PMT_OFF_COUNT, 32'h00000033);
    apb(1'b1, PMT_OFF_CONTROL, 32'h000000FB);
    rd(PMT_OFF_CONTROL, 32'h0000007B);
    repeat (40) @(posedge pclk);
    rd(PMT_OFF_COUNT, 32'h00000033);
    apb(1'b0, 12'h018, 32'h00000000);
    chk(ev, 1'b1, "unmapped read not refused");
    $display("register test done");
  endtask
  task t_prescale;
    int n;
    int div;
    for (int c = 0; c < 4; c++) begin
      div = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      apb(1'b1, PMT_OFF_CONTROL, 32'h00000000);
      apb(1'b1, PMT_OFF_LIMIT, 32'h00000003);
      apb(1'b1, PMT_OFF_COUNT, 32'h00000000);
      apb(1'b1, PMT_OFF_CONTROL, 32'(4 + c));
      wait_pulse(n);
      wait_pulse(n);
      chk(shift, 1'b1, "shift tick missing with match");
      chk(32'(n), 32'(4 * div * FOSC), "match period");
    end
    $display("prescale test done");
  endtask
  task t_post;
    int n;
    int ps;
    for (int k = 0; k < 3; k++) begin
      ps = (k == 0) ? 0 : (k == 1) ? 3 : 15;
      apb(1'b1, PMT_OFF_CONTROL, 32'h00000000);
      apb(1'b1, PMT_OFF_LIMIT, 32'h00000000);
      apb(1'b1, PMT_OFF_IRQ_CLEAR, 32'h00000001);
      apb(1'b1, PMT_OFF_IRQ_ENABLE, 32'h00000001);
      apb(1'b1, PMT_OFF_COUNT, 32'h00000000);
      rd(PMT_OFF_IRQ_STATUS, 32'h00000000);
      apb(1'b1, PMT_OFF_CONTROL, 32'(ps * 8 + 4));
      n = 0;
      for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
        @(negedge pclk);
        if (pwm === 1'b1) n++;
      end
      chk(32'(n), 32'(ps + 1), "matches per interrupt");
    end
    apb(1'b1, PMT_OFF_CONTROL, 32'h00000000);
    apb(1'b1, PMT_OFF_IRQ_ENABLE, 32'h00000000);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0, "masked irq high");
    rd(PMT_OFF_IRQ_STATUS, 32'h00000001);
    apb(1'b1, PMT_OFF_IRQ_CLEAR, 32'h00000001);
    rd(PMT_OFF_IRQ_STATUS, 32'h00000000);
    $display("postscale test done");
  endtask
  task t_clear;
    int n;
    apb(1'b1, PMT_OFF_COUNT, 32'h00000000);
    apb(1'b1, PMT_OFF_CONTROL, 32'h00000006);
    wait_pulse(n);
    repeat (32) @(negedge pclk);
    apb(1'b1, PMT_OFF_COUNT, 32'h00000000);
    wait_pulse(n);
    chk(32'(n >= 56 && n <= 68), 32'h00000001, "prescaler not restarted");
    apb(1'b1, PMT_OFF_CONTROL, 32'h00000000);
    $display("scaler clear test done");
  endtask
  // reset in mid-run must bring back every documented reset value
  task t_reset;
    int n;
    apb(1'b1, PMT_OFF_LIMIT, 32'h00000001);
    apb(1'b1, PMT_OFF_COUNT, 32'h00000000);
    apb(1'b1, PMT_OFF_CONTROL, 32'h00000004);
    wait_pulse(n);
    rd(PMT_OFF_IRQ_STATUS, 32'h00000001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(PMT_OFF_CONTROL, 32'h00000000);
    rd(PMT_OFF_LIMIT, 32'h000000FF);
    rd(PMT_OFF_COUNT, 32'h00000000);
    rd(PMT_OFF_IRQ_STATUS, 32'h00000000);
    rd(PMT_OFF_IRQ_ENABLE, 32'h00000000);
    repeat (40) @(posedge pclk);
    rd(PMT_OFF_COUNT, 32'h00000000);
    $display("mid-run reset test done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    err_total = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_prescale();
    t_post();
    t_clear();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
